//--- sbu_pkg.sv
// Purpose: shared constants and types for the serial bus block
// Assumes: 100 MHz clk, 8-bit registers on a 32-bit Wishbone bus
// Notes:   register index times four gives the byte address
package sbu_pkg;
  localparam int ADR_W = 8;
  // Register indices; UART and sync port share 5..7, selected by bank
  localparam logic [3:0] IDX_UC1  = 4'h5;
  localparam logic [3:0] IDX_UC2  = 4'h6;
  localparam logic [3:0] IDX_UST  = 4'h7;
  localparam logic [3:0] IDX_URX  = 4'h8;
  localparam logic [3:0] IDX_UTX  = 4'h9;
  localparam logic [3:0] IDX_SC1  = 4'h5;
  localparam logic [3:0] IDX_SC2  = 4'h6;
  localparam logic [3:0] IDX_SDB  = 4'h7;
  localparam logic [3:0] IDX_BANK = 4'hC;
  localparam logic [3:0] IDX_IEN  = 4'hD;
  // Baud prescale (16 ticks per bit) and sync port clock exponents
  localparam logic [8:0] BAUD_DIV [6] = '{9'h00D, 9'h01A, 9'h034, 9'h068, 9'h0D0, 9'h1A0};
  localparam logic [3:0] SCK_EXP  [6] = '{4'hD, 4'hB, 4'hA, 4'h8, 4'h6, 4'h5};
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [2:0] RATE_TC4 = 3'b110;
  localparam logic [2:0] BRS_SS   = 3'b110;
  localparam logic [1:0] DIR_TX   = 2'b01;
  localparam logic [1:0] DIR_RX   = 2'b10;
  localparam logic [1:0] LEN_7    = 2'b00;
  localparam logic [1:0] LEN_9    = 2'b10;

  typedef enum logic [1:0] {SBU_IO = 2'b00, SBU_SPI = 2'b01, SBU_UART = 2'b10, SBU_RSV = 2'b11} sbu_mode_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10} sbu_rx_e;

  typedef struct packed {
    logic ack; logic [7:0] dat; logic bank; logic [3:0] ien;
    logic tx9; logic [1:0] clen; logic [2:0] brate; logic tbe; logic transmit_enable;
    sbu_mode_e mode; logic inv;
    logic rx9; logic even; logic pe; logic perr; logic oerr; logic ferr; logic sync_rx_full_flag; logic receive_enable;
    logic [7:0] rxbuf; logic [7:0] txbuf; logic tpend;
    logic [8:0] bcnt; logic [3:0] tsub; logic tbusy; logic [11:0] tsh; logic [3:0] tcnt; logic txd;
    sbu_rx_e rst; logic [3:0] rsub; logic [3:0] rcnt; logic [10:0] rsh;
    logic sample_phase_sel; logic collision_flag; logic [2:0] brs; logic shift_edge_sel; logic bit_order_sel; logic write_buffer_flag; logic start;
    logic [1:0] tdir; logic srbf; logic [7:0] sdata; logic sbusy;
    logic [7:0] ssh; logic sbit; logic [3:0] shalf; logic [3:0] scnt; logic sck; logic [12:0] pre;
    logic [1:0] rxs; logic [2:0] scks; logic [1:0] sss; logic [1:0] sdis; logic sdo; logic [3:0] irq;
  } sbu_state_s;

  localparam sbu_state_s SBU_RST = '{tbe: 1'b1, txd: 1'b1, sck: 1'b1, rxs: 2'b11, scks: 3'b111,
                                     sss: 2'b11, mode: SBU_IO, rst: RX_IDLE, default: '0};
endpackage : sbu_pkg

//--- sbu_top.sv
// Purpose: UART and synchronous serial port sharing one pin group
// Assumes: classic Wishbone slave, registers banked by a bank register
// Notes:   all state is one struct; ce low freezes every flop
// What this block does
// R1: character length field picks 7, 8, 9 bits
// R2: rate field divides clock or uses timer four
// R3: ninth bit sent and received via own bits
// R4: tx empty flag clears on tx buffer write
// R5: enabling transmit clears the tx empty flag
// R6: enable bits gate transmit and receive
// R7: mode field picks I/O, sync or UART
// R8: invert bit flips UART tx and rx lines
// R9: parity enable adds and checks odd/even parity
// R10: error flags stick until written zero
// R11: rx full flag clears on status read
// R12: enabling receive clears the rx full flag
// R13: rx buffer read only, tx buffer write only
// R14: sample phase: middle or end of bit
// R15: collision flag set by hardware, software clears
// R16: clock field picks divider or external clock
// R17: edge select picks the shift-out edge
// R18: bit order picks MSB or LSB first
// R19: write buffer flag sets on data write
// R20: start bit runs shifter, clears when done
// R21: direction field picks tx/rx, tx, rx
// R22: sync rx full clears on read or enable
// R23: four separately maskable interrupt requests
// R24: start bit low, stop bit high, framing check
// R25: one byte per start through one shifter
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module sbu_top
  import sbu_pkg::*;
(
  input  wire logic                      clk,               // System clock
  input  wire logic                      rst_n,             // Async reset
  input  wire logic                      ce,                // Clock enable
  input  wire logic                      wb_cyc_i,          // Bus cycle
  input  wire logic                      wb_stb_i,          // Strobe
  input  wire logic                      wb_we_i,           // Write
  input  wire logic [sbu_pkg::ADR_W-1:0] wb_adr_i,          // Byte address
  input  wire logic [3:0]                wb_sel_i,          // Byte enables
  input  wire logic [31:0]               wb_dat_i,          // Write data
  output logic      [31:0]               wb_dat_o,          // Read data
  output logic                           wb_ack_o,          // Ack
  input  wire logic                      timer_four_output, // Timer pulse
  input  wire logic                      uart_rxd,          // UART in
  output logic                           uart_txd,          // UART out
  input  wire logic                      spi_sck_i,         // Clock in
  output logic                           spi_sck_o,         // Clock out
  output logic                           spi_sck_oe,        // Clock drive
  input  wire logic                      spi_ss_n,          // Select
  input  wire logic                      spi_sdi,           // Data in
  output logic                           spi_sdo,           // Data out
  output logic                           spi_sdo_oe,        // Data drive
  output logic                           irq_rx_err,        // Rx error
  output logic                           irq_rx_full,       // Rx full
  output logic                           irq_tx_empty,      // Tx empty
  output logic                           irq_spi            // Sync done
);
  import sbu_pkg::*;

  sbu_state_s s;
  sbu_state_s n;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [3:0] idx;
  logic [7:0] wd;
  logic       tick;
  logic       rx_done;
  logic       spi_done;
  logic       master;
  logic       sel;
  logic       rin;
  logic [3:0] nb;
  logic [10:0] rb;
  logic [15:0] fr;
  logic       pchk;
  logic       bin;
  logic       mid_e;
  logic       sft_e;

  function automatic logic [3:0] data_bits(input logic [1:0] cl);
    return (cl == LEN_7) ? 4'h7 : (cl == LEN_9) ? 4'h9 : 4'h8; // R1
  endfunction : data_bits

  function automatic logic [8:0] baud_div(input logic [2:0] r);
    return BAUD_DIV[r];
  endfunction : baud_div

  function automatic logic [12:0] half_mask(input logic [2:0] b);
    return 13'((13'h0001 << (SCK_EXP[b] - 4'h1)) - 13'h0001);
  endfunction : half_mask

  function automatic logic [15:0] tx_frame(input logic [8:0] d, input logic [1:0] cl,
                                           input logic pe, input logic ev);
    logic [11:0] f;
    logic [3:0]  k;
    logic        p;
    f = 12'hFFE; // R24
    k = data_bits(cl);
    p = ~ev;
    for (int i = 0; i < 9; i++)
    begin
      if (4'(i) < k)
      begin
        f[i + 1] = d[i];
        p = p ^ d[i];
      end
    end
    if (pe)
      f[int'(k) + 1] = p; // R9
    return {4'(k + 4'(pe) + 4'h2), f};
  endfunction : tx_frame

  function automatic logic [7:0] shift_in(input logic [7:0] r, input logic b, input logic lsb);
    return lsb ? {b, r[7:1]} : {r[6:0], b}; // R18
  endfunction : shift_in

  always_comb
  begin
    n = s;
    n.rxs  = {s.rxs[0], uart_rxd};
    n.scks = {s.scks[1:0], spi_sck_i};
    n.sss  = {s.sss[0], spi_ss_n};
    n.sdis = {s.sdis[0], spi_sdi};
    idx = wb_adr_i[5:2];
    hit = wb_adr_i[7:6] == 2'b00;
    wd  = wb_dat_i[7:0];
    wr  = wb_cyc_i & wb_stb_i & s.ack & wb_we_i & wb_sel_i[0] & hit;
    rd  = wb_cyc_i & wb_stb_i & s.ack & ~wb_we_i & hit;
    n.ack = wb_cyc_i & wb_stb_i & ~s.ack;
    tick = 1'b0;
    rx_done = 1'b0;
    spi_done = 1'b0;
    nb = data_bits(s.clen);
    rb = s.rsh;
    fr = tx_frame({s.tx9, s.txbuf}, s.clen, s.pe, s.even);
    pchk = 1'b0;
    bin = 1'b0;
    master = s.brs < BRS_SS; // R16
    sel = (s.brs != BRS_SS) | ~s.sss[1];
    rin = s.rxs[1] ^ s.inv; // R8
    mid_e = s.shift_edge_sel ? (s.scks[1] & ~s.scks[2]) : (~s.scks[1] & s.scks[2]); // R17
    sft_e = s.shift_edge_sel ? (~s.scks[1] & s.scks[2]) : (s.scks[1] & ~s.scks[2]);

    if (wb_cyc_i & wb_stb_i & ~s.ack)
    begin
      n.dat = 8'h00;
      if (hit)
      begin
        case ({s.bank, idx})
          {1'b0, IDX_UC1}: n.dat = {s.tx9, s.clen, s.brate, s.tbe, s.transmit_enable};
          {1'b0, IDX_UC2}: n.dat = {2'b00, s.mode, s.inv, 3'b000};
          {1'b0, IDX_UST}: n.dat = {s.rx9, s.even, s.pe, s.perr, s.oerr, s.ferr, s.sync_rx_full_flag, s.receive_enable};
          {1'b0, IDX_URX}: n.dat = s.rxbuf; // R13
          {1'b1, IDX_SC1}: n.dat = {s.sample_phase_sel, s.collision_flag, s.brs, s.shift_edge_sel, s.bit_order_sel, s.write_buffer_flag};
          {1'b1, IDX_SC2}: n.dat = {s.start, 4'h0, s.tdir, s.srbf};
          {1'b1, IDX_SDB}: n.dat = s.sdata;
          {1'b0, IDX_BANK}, {1'b1, IDX_BANK}: n.dat = {7'h00, s.bank};
          {1'b0, IDX_IEN}, {1'b1, IDX_IEN}: n.dat = {4'h0, s.ien};
          default: n.dat = 8'h00;
        endcase
      end
    end

    // Clears first; hardware sets below override them
    if (rd && !s.bank && idx == IDX_UST && s.dat[1])
      n.sync_rx_full_flag = 1'b0; // R11
    if (rd && s.bank && idx == IDX_SDB)
      n.srbf = 1'b0; // R22
    if (wr)
    begin
      case ({s.bank, idx})
        {1'b0, IDX_UC1}:
        begin
          {n.tx9, n.clen, n.brate} = wd[7:2];
          n.transmit_enable = wd[0];
          if (wd[0] & ~s.transmit_enable)
            n.tbe = 1'b0; // R5
        end
        {1'b0, IDX_UC2}:
        begin
          n.mode = sbu_mode_e'(wd[5:4]); // R7
          n.inv = wd[3];
          if (wd[5:4] == SBU_SPI && s.mode != SBU_SPI)
            n.srbf = 1'b0; // R22
        end
        {1'b0, IDX_UST}:
        begin
          {n.even, n.pe} = wd[6:5];
          n.perr = s.perr & wd[4]; // R10
          n.oerr = s.oerr & wd[3];
          n.ferr = s.ferr & wd[2];
          n.receive_enable = wd[0];
          if (wd[0] & ~s.receive_enable)
            n.sync_rx_full_flag = 1'b0; // R12
        end
        {1'b0, IDX_UTX}:
        begin
          n.txbuf = wd; // R13
          n.tpend = 1'b1;
          n.tbe = 1'b0; // R4
        end
        {1'b1, IDX_SC1}:
        begin
          n.sample_phase_sel = wd[7];
          n.collision_flag = s.collision_flag & wd[6]; // R15
          {n.brs, n.shift_edge_sel, n.bit_order_sel} = wd[5:1];
        end
        {1'b1, IDX_SC2}:
        begin
          n.start = s.start | wd[7]; // R20
          n.tdir = wd[2:1]; // R21
        end
        {1'b1, IDX_SDB}:
        begin
          if (s.sbusy)
            n.collision_flag = 1'b1; // R15
          else
          begin
            n.sdata = wd;
            n.write_buffer_flag = 1'b1; // R19
          end
        end
        {1'b0, IDX_BANK}, {1'b1, IDX_BANK}: n.bank = wd[0];
        {1'b0, IDX_IEN}, {1'b1, IDX_IEN}: n.ien = wd[3:0];
        default: n.bcnt = n.bcnt;
      endcase
    end

    // Baud tick, sixteen per bit
    if (s.mode == SBU_UART)
    begin
      if (s.brate == RATE_TC4)
        tick = timer_four_output; // R2
      else if (s.brate < RATE_TC4)
      begin
        tick = s.bcnt >= baud_div(s.brate) - 9'h001; // R2
        n.bcnt = tick ? 9'h000 : s.bcnt + 9'h001;
      end
    end

    // Transmitter
    if (!s.transmit_enable || s.mode != SBU_UART)
      n.tbusy = 1'b0; // R6
    else if (!s.tbusy && s.tpend)
    begin
      n.tsh = fr[11:0]; // R3
      n.tcnt = fr[15:12];
      n.tsub = 4'h0;
      n.tbusy = 1'b1;
      n.tpend = 1'b0;
      n.tbe = 1'b1; // R4
    end
    else if (s.tbusy && tick)
    begin
      n.tsub = s.tsub + 4'h1;
      if (s.tsub == OVS_LAST)
      begin
        n.tsh = {1'b1, s.tsh[11:1]};
        n.tcnt = s.tcnt - 4'h1;
        if (s.tcnt == 4'h1)
          n.tbusy = 1'b0;
      end
    end

    // Receiver
    if (!s.receive_enable || s.mode != SBU_UART)
      n.rst = RX_IDLE; // R6
    else
    begin
      case (s.rst)
        RX_IDLE:
        begin
          n.rsub = 4'h0;
          if (!rin)
            n.rst = RX_START;
        end
        RX_START:
        begin
          if (tick)
          begin
            n.rsub = s.rsub + 4'h1;
            if (s.rsub == OVS_MID)
            begin
              n.rst = rin ? RX_IDLE : RX_BITS; // R24
              n.rsub = 4'h0;
              n.rcnt = 4'h0;
            end
          end
        end
        RX_BITS:
        begin
          if (tick)
          begin
            n.rsub = s.rsub + 4'h1;
            if (s.rsub == OVS_LAST)
            begin
              rb[s.rcnt] = rin;
              n.rsh = rb;
              n.rcnt = s.rcnt + 4'h1;
              if (s.rcnt == nb + 4'(s.pe))
              begin
                rx_done = 1'b1;
                n.rst = RX_IDLE;
              end
            end
          end
        end
        default: n.rst = RX_IDLE;
      endcase
    end
    if (rx_done)
    begin
      pchk = ~s.even;
      for (int i = 0; i < 9; i++)
      begin
        if (4'(i) < nb)
          pchk = pchk ^ rb[i];
        if (i < 8)
          n.rxbuf[i] = (4'(i) < nb) & rb[i];
      end
      n.rx9 = (nb == 4'h9) & rb[8]; // R3
      if (s.pe && rb[nb] != pchk)
        n.perr = 1'b1; // R9
      if (!rb[int'(nb) + int'(s.pe)])
        n.ferr = 1'b1; // R24
      if (n.sync_rx_full_flag)
        n.oerr = 1'b1; // R10
      n.sync_rx_full_flag = 1'b1; // R11
    end

    // Sync port: one shifter, one byte per start
    n.pre = (s.mode == SBU_SPI) ? s.pre + 13'h0001 : 13'h0000;
    if (s.mode != SBU_SPI)
    begin
      n.sbusy = 1'b0;
      n.sck = ~s.shift_edge_sel;
    end
    else if (!s.sbusy)
    begin
      n.sck = ~s.shift_edge_sel;
      n.shalf = 4'h0;
      n.scnt = 4'h0;
      if (s.start && (master || sel))
      begin
        n.ssh = s.sdata; // R25
        n.sbusy = 1'b1;
        n.write_buffer_flag = 1'b0; // R19
      end
    end
    else if (master)
    begin
      if ((s.pre & half_mask(s.brs)) == half_mask(s.brs)) // R16
      begin
        n.shalf = s.shalf + 4'h1;
        n.sck = ~s.sck;
        if (!s.shalf[0])
        begin
          if (!s.sample_phase_sel)
            n.sbit = s.sdis[1]; // R14
        end
        else
        begin
          bin = s.sample_phase_sel ? s.sdis[1] : s.sbit; // R14
          n.ssh = shift_in(s.ssh, bin, s.bit_order_sel);
          spi_done = s.shalf == 4'hF;
        end
      end
    end
    else if (!sel)
      n.scnt = 4'h0;
    else if (mid_e)
    begin
      n.sbit = s.sdis[1]; // R14
      n.scnt = s.scnt + 4'h1;
      if (s.scnt == 4'h7)
      begin
        n.ssh = shift_in(s.ssh, s.sdis[1], s.bit_order_sel);
        spi_done = 1'b1;
      end
    end
    else if (sft_e && s.scnt != 4'h0)
      n.ssh = shift_in(s.ssh, s.sbit, s.bit_order_sel);
    if (spi_done)
    begin
      n.start = 1'b0; // R20
      n.sbusy = 1'b0;
      if (s.tdir != DIR_TX)
      begin
        n.sdata = n.ssh; // R25
        if (n.srbf)
          n.collision_flag = 1'b1; // R15
        n.srbf = 1'b1; // R22
      end
    end

    // Mode and invert follow the same edge, so no wrong idle level after a mode write
    n.txd = (n.mode != SBU_UART) | ((n.tbusy ? n.tsh[0] : 1'b1) ^ n.inv); // R8
    n.sdo = n.bit_order_sel ? n.ssh[0] : n.ssh[7]; // R18
    n.irq = s.ien & {n.perr | n.oerr | n.ferr, n.sync_rx_full_flag, n.tbe, spi_done}; // R23
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= SBU_RST;
    else if (ce)
      s <= n;
  end

  assign wb_dat_o     = {24'h000000, s.dat};
  assign wb_ack_o     = s.ack;
  assign uart_txd     = s.txd;
  assign spi_sck_o    = s.sck;
  assign spi_sck_oe   = (s.mode == SBU_SPI) & master;
  assign spi_sdo      = s.sdo;
  assign spi_sdo_oe   = (s.mode == SBU_SPI) & (s.tdir != DIR_RX) & (master | sel); // R21
  assign irq_rx_err   = s.irq[3];
  assign irq_rx_full  = s.irq[2];
  assign irq_tx_empty = s.irq[1];
  assign irq_spi      = s.irq[0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || !ce);

  sequence s_tx_load;
    $rose(s.tbusy);
  endsequence
  sequence s_master_edge;
    $changed(s.sck) && s.sbusy && master && s.brs == 3'b101;
  endsequence

  chk_tbe_on_write: assert property (wr && !s.bank && idx == IDX_UTX |=> !s.tbe) // R4
    else $error("tx empty flag not cleared by buffer write");
  chk_tx_gate: assert property (s_tx_load |-> $past(s.transmit_enable) && s.tbe) // R6
    else $error("transmit started while disabled");
  chk_start_low: assert property (s_tx_load |-> uart_txd == s.inv) // R24
    else $error("start bit not low");
  chk_idle_level: assert property (!s.tbusy && s.mode == SBU_UART |-> uart_txd == !s.inv) // R8
    else $error("idle line level wrong");
  chk_baud_div13: assert property (tick && s.mode == SBU_UART && s.brate == 3'b000 |->
                                   ##13 (tick || s.mode != SBU_UART || s.brate != 3'b000)) // R2
    else $error("baud tick not every 13 cycles");
  chk_rbf_read: assert property (rd && !s.bank && idx == IDX_UST && s.dat[1] && !rx_done |=> !s.sync_rx_full_flag) // R11
    else $error("rx full not cleared by status read");
  chk_ferr_sticky: assert property (s.ferr && !(wr && !s.bank && idx == IDX_UST) |=> s.ferr) // R10
    else $error("framing flag dropped without write");
  chk_start_clear: assert property (spi_done |=> !s.start && !s.sbusy) // R20
    else $error("start bit not cleared after byte");
  chk_wbe_set: assert property (wr && s.bank && idx == IDX_SDB && !s.sbusy |=> s.write_buffer_flag) // R19
    else $error("write buffer flag not set");
  chk_sck_half: assert property (s_master_edge |-> ##16 ($changed(s.sck) || !s.sbusy)) // R16
    else $error("clock half period not 16 cycles");
endmodule : sbu_top

//--- sbu_peer.sv
// Purpose: remote serial device at the pins: UART sender and receiver, sync port echo slave
// Assumes: UART at 8 data bits; sync port clock idles high, so falling edges are mid-bit
// Notes:   the slave echoes data out straight back in and records what it saw
`timescale 1ns/1ps
module sbu_peer #(
  parameter int BIT = 208
) (
  input  wire logic       clk,   // System clock
  input  wire logic       txd,   // Line from the block
  output logic            rxd,   // Line to the block
  input  wire logic       sck,   // Sync clock from the block
  input  wire logic       sdo,   // Sync data from the block
  output logic            sdi,   // Sync data to the block
  output logic      [7:0] got,   // Last byte received
  output logic            got_v, // One-cycle pulse per byte
  output logic      [7:0] cap    // Bits seen on sdo
);
  logic [7:0] d;
  initial
  begin
    rxd = 1'b1;
    got = '0;
    got_v = 1'b0;
    cap = '0;
  end
  assign sdi = sdo;
  always @(negedge sck) cap <= {cap[6:0], sdo};
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clk);
      d[i] = txd;
    end
    repeat (BIT) @(posedge clk);
    got <= d;
    got_v <= 1'b1;
    @(posedge clk);
    got_v <= 1'b0;
  end
  // Parity bit is for even parity, flip makes it wrong
  task automatic send(input logic [7:0] v, input logic par, input logic flip, input logic stp);
    logic [10:0] f;
    int n;
    f = par ? {stp, ^v ^ flip, v, 1'b0} : {1'b1, stp, v, 1'b0};
    n = par ? 11 : 10;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask : send
endmodule : sbu_peer

//--- sbu_top_tb.sv
// Purpose: self-checking bench for the serial bus block
// Assumes: UART at rate 000 with 8 data bits; sync port at clock code 101
// Notes:   sent UART bytes are checked through a queue of expected values
`timescale 1ns/1ps
module sbu_top_tb;
  import sbu_pkg::*;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = '0, rq, b, rv, got, cap;
  logic [31:0] wdat = '0, rdat;
  logic        ack, txd, rxd, sck, sck_oe, sdi, sdo, sdo_oe, i_err, i_full, i_tx, i_spi, got_v;
  logic [7:0]  exp_q[$];
  int          err_total = 0, cmp_count = 0, seed = 72, spi_irqs = 0;
  always #5 clk = ~clk;
  sbu_top DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer_four_output(1'b0), .uart_rxd(rxd), .uart_txd(txd), .spi_sck_i(1'b0), .spi_sck_o(sck),
    .spi_sck_oe(sck_oe), .spi_ss_n(1'b1), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
    .irq_rx_err(i_err), .irq_rx_full(i_full), .irq_tx_empty(i_tx), .irq_spi(i_spi));
  sbu_peer peer (.clk(clk), .txd(txd), .rxd(rxd), .sck(sck), .sdo(sdo), .sdi(sdi),
    .got(got), .got_v(got_v), .cap(cap));
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      $display("BAD %s exp %h seen %h", n, e, s);
      err_total++;
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    // Ends on ack; if ack never comes, only the watchdog ends this wait
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    rq = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic poll(input logic [7:0] a, input int k, input logic v);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, a, 8'h00);
      n++;
    end
    while (rq[k] !== v && n < 1500);
    if (n >= 1500)
    begin
      err_total++;
      print_verdict();
    end
  endtask : poll
  // Every byte seen on the line must be the oldest one still expected
  always @(posedge clk)
    if (got_v === 1'b1)
    begin
      if (exp_q.size() == 0) chk("tx_extra", 8'h01, 8'h00);
      else chk("tx_byte", got, exp_q.pop_front());
    end
  // Sync done pulses, one per byte
  always @(posedge clk)
    if (i_spi === 1'b1) spi_irqs++;
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 8'h14, 8'h00);
    chk("ctrl1_rst", rq, 8'h02);
    wb(1'b0, 8'hC0, 8'h00);
    chk("unmapped", rq, 8'h00);
    wb(1'b1, 8'h18, 8'h20);
    wb(1'b1, 8'h14, 8'h21);
    wb(1'b1, 8'h34, 8'h0F);
    wb(1'b0, 8'h14, 8'h00);
    chk("tbe_on_en", rq, 8'h21);
    chk("oe_uart", {6'h00, sck_oe, sdo_oe}, 8'h00);
    b = 8'($random(seed));
    exp_q.push_back(b);
    wb(1'b1, 8'h24, b);
    for (int n = 0; n < 4000 && exp_q.size() != 0; n++) @(posedge clk);
    chk("tx_left", 8'(exp_q.size()), 8'h00);
    wb(1'b0, 8'h14, 8'h00);
    chk("tbe_empty", rq, 8'h23);
    chk("irq_tx", {7'h00, i_tx}, 8'h01);
    wb(1'b0, 8'h24, 8'h00);
    chk("tx_wo", rq, 8'h00);
    wb(1'b1, 8'h14, 8'h20);
    wb(1'b1, 8'h24, 8'(seed));
    repeat (2500) @(posedge clk);
    wb(1'b1, 8'h1C, 8'h01);
    b = 8'($random(seed));
    peer.send(b, 1'b0, 1'b0, 1'b1);
    chk("irq_full", {7'h00, i_full}, 8'h01);
    poll(8'h1C, 1, 1'b1);
    chk("rx_stat", rq, 8'h03);
    wb(1'b0, 8'h20, 8'h00);
    chk("rx_data", rq, b);
    wb(1'b0, 8'h1C, 8'h00);
    chk("rbf_clr", rq, 8'h01);
    chk("irq_full_clr", {7'h00, i_full}, 8'h00);
    wb(1'b1, 8'h1C, 8'h61);
    peer.send(b, 1'b1, 1'b1, 1'b1);
    poll(8'h1C, 1, 1'b1);
    chk("perr", rq, 8'h73);
    chk("irq_err", {7'h00, i_err}, 8'h01);
    wb(1'b1, 8'h1C, 8'h61);
    wb(1'b0, 8'h1C, 8'h00);
    chk("perr_clr", rq, 8'h61);
    chk("irq_err_clr", {7'h00, i_err}, 8'h00);
    wb(1'b1, 8'h1C, 8'h01);
    peer.send(b, 1'b0, 1'b0, 1'b0);
    poll(8'h1C, 1, 1'b1);
    chk("ferr", rq, 8'h07);
    wb(1'b1, 8'h18, 8'h10);
    wb(1'b1, 8'h30, 8'h01);
    for (int o = 0; o < 2; o++)
    begin
      wb(1'b1, 8'h14, 8'h28 | 8'(o << 1));
      chk("oe_spi", {6'h00, sck_oe, sdo_oe}, 8'h03);
      b = 8'($random(seed));
      wb(1'b1, 8'h1C, b);
      wb(1'b0, 8'h14, 8'h00);
      chk("wbuf", rq, 8'h29 | 8'(o << 1));
      wb(1'b1, 8'h18, 8'h80);
      poll(8'h18, 7, 1'b0);
      chk("spi_done", rq, 8'h01);
      wb(1'b0, 8'h1C, 8'h00);
      chk("spi_rx", rq, b);
      wb(1'b0, 8'h18, 8'h00);
      chk("srbf_clr", rq, 8'h00);
      rv = {<<{b}};
      chk("spi_order", cap, o ? rv : b);
    end
    chk("irq_spi", 8'(spi_irqs), 8'h02);
    print_verdict();
  end
endmodule : sbu_top_tb
